/* File: switch_input_config_decoder.sv */
// switch input config decoder: serial command decode, per-input drive, timers
// assumes serial lines and comparator levels come from outside the clock domain
// Functional notes
// - level bit picks low or high contact current
// - codes 04/05 load contact level bits
// - each input has own 20 ms timer
// - timer expiry drops current to low level
// - disabled timer keeps selected current flowing
// - codes 07/08 load timer enable bits
// - tri-state bit forces input high impedance unless analog-selected
// - comparator stays active while high impedance
// - code 06 current select: hiz, low, high
// - select value 11 acts as high impedance
// - five-bit channel field routes analog output
// - analog-selected input reports zero status
// - analog current is pull-up only
// - registers update any time in normal mode with supply
// - reset clears calibration
// - frames are exactly 24 bits
// - programming only in normal mode with supply
// - reset enables every timer
`timescale 1ns/1ps
module switch_input_config_decoder
  import swcfg_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  sclk_i,
  input  wire logic                  cs_n_i,
  input  wire logic                  sdi_i,
  input  wire logic                  normal_mode_i,
  input  wire logic                  logic_supply_i,
  input  wire logic [NUM_INPUTS-1:0] comp_closed_i,
  output logic [NUM_INPUTS-1:0]      comp_status_o,
  output logic [NUM_INPUTS-1:0]      pull_en_o,
  output logic [NUM_INPUTS-1:0]      high_level_o,
  output logic [NUM_INPUTS-1:0]      pull_up_o,
  output logic                       analog_en_o,
  output logic [4:0]                 analog_chan_o,
  output logic                       calibrated_o,
  output logic [CNT_W-1:0]           hold_cycles_o
);

  import swcfg_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0]            sclk_meta_q, sclk_sync_q;
  logic [NUM_INPUTS-1:0] comp_meta_q, comp_sync_q, comp_prev_q;
  logic [2:0]            pin_meta;
  logic                  sclk_prev_q;
  logic                  cs_prev_q;

  assign pin_meta = {sclk_i, cs_n_i, sdi_i};

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sclk_meta_q <= 3'h2;
      sclk_sync_q <= 3'h2;
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end
    else
    begin
      sclk_meta_q <= pin_meta;
      sclk_sync_q <= sclk_meta_q;
      sclk_prev_q <= sclk_sync_q[2];
      cs_prev_q   <= sclk_sync_q[1];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      comp_meta_q <= '0;
      comp_sync_q <= '0;
      comp_prev_q <= '0;
    end
    else
    begin
      comp_meta_q <= comp_closed_i;
      comp_sync_q <= comp_meta_q;
      comp_prev_q <= comp_sync_q;
    end
  end

  logic sclk_s, cs_n_s, sdi_s, sclk_rise, cs_fall, cs_rise;
  assign sclk_s    = sclk_sync_q[2];
  assign cs_n_s    = sclk_sync_q[1];
  assign sdi_s     = sclk_sync_q[0];
  assign sclk_rise = sclk_s && !sclk_prev_q;
  assign cs_fall   = !cs_n_s && cs_prev_q;
  assign cs_rise   = cs_n_s && !cs_prev_q;

  // ----------------------------------------
  // frame shift
  // ----------------------------------------
  logic [FRAME_BITS-1:0] shift_q;
  logic [4:0]            nbits_q;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      shift_q <= '0;
      nbits_q <= '0;
    end
    else if (cs_fall)
    begin
      nbits_q <= '0;
    end
    else if (!cs_n_s && sclk_rise)
    begin
      shift_q <= {shift_q[FRAME_BITS-2:0], sdi_s};
      if (nbits_q != 5'd31)
      begin
        nbits_q <= nbits_q + 5'd1;
      end
    end
  end

  frame_type frame;
  logic      cmd_ok;
  assign frame  = frame_type'(shift_q);
  assign cmd_ok = cs_rise && (nbits_q == 5'(FRAME_BITS))
                  && normal_mode_i && logic_supply_i;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [NUM_INPUTS-1:0] level_q, timer_en_q, hiz_q;
  logic [6:0]            analog_q;
  logic                  soft_rst;

  assign soft_rst = cmd_ok && (frame.code == CMD_RESET);

  // ground inputs in bits 13..0, programmable in 21..14
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      level_q    <= LEVEL_RESET;
      timer_en_q <= TIMER_RESET;
      hiz_q      <= HIZ_RESET;
      analog_q   <= ANALOG_RESET;
    end
    else if (soft_rst)
    begin
      level_q    <= LEVEL_RESET;
      timer_en_q <= TIMER_RESET;
      hiz_q      <= HIZ_RESET;
      analog_q   <= ANALOG_RESET;
    end
    else if (cmd_ok)
    begin
      unique case (frame.code)
        CMD_LEVEL_PROG: level_q[21:14]    <= frame.data[7:0];
        CMD_LEVEL_GND:  level_q[13:0]     <= frame.data[13:0];
        CMD_TIMER_PROG: timer_en_q[21:14] <= frame.data[7:0];
        CMD_TIMER_GND:  timer_en_q[13:0]  <= frame.data[13:0];
        CMD_HIZ_PROG:   hiz_q[21:14]      <= frame.data[7:0];
        CMD_HIZ_GND:    hiz_q[13:0]       <= frame.data[13:0];
        CMD_ANALOG:     analog_q          <= frame.data[6:0];
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // calibration
  // ----------------------------------------
  cal_state_type    cal_q;
  logic [CNT_W-1:0] cal_cnt_q;
  logic [CNT_W-1:0] hold_len_q;
  logic             calibrated_q;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cal_q        <= CAL_IDLE;
      cal_cnt_q    <= '0;
      hold_len_q   <= CNT_W'(HOLD_CYCLES);
      calibrated_q <= 1'b0;
    end
    else if (soft_rst)
    begin
      cal_q        <= CAL_IDLE;
      hold_len_q   <= CNT_W'(HOLD_CYCLES);
      calibrated_q <= 1'b0;
    end
    else
    begin
      unique case (cal_q)
        CAL_IDLE:
        begin
          if (cmd_ok && frame.code == CMD_CALIBRATE)
          begin
            cal_q <= CAL_ARMED;
          end
        end
        CAL_ARMED:
        begin
          if (cs_fall)
          begin
            cal_cnt_q <= '0;
            cal_q     <= CAL_MEASURE;
          end
        end
        CAL_MEASURE:
        begin
          // sclk and sdi assumed still during the pulse
          if (cs_rise)
          begin
            cal_q        <= CAL_IDLE;
            calibrated_q <= (cal_cnt_q != '0);
            if (cal_cnt_q != '0)
            begin
              // scale 20 ms by the measured 512 us length
              hold_len_q <= CNT_W'((64'(cal_cnt_q) * HOLD_CYCLES) / CAL_CYCLES);
            end
          end
          else if (cal_cnt_q != '1)
          begin
            cal_cnt_q <= cal_cnt_q + 32'd1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // per-input drive
  // ----------------------------------------
  logic [NUM_INPUTS-1:0] timer_high, ana_sel;
  logic [1:0]            ana_cur;
  assign ana_cur = analog_q[CUR_SEL_MSB:CUR_SEL_LSB];

  for (genvar i = 0; i < NUM_INPUTS; i++)
  begin : g_input
    localparam logic [4:0] CH = (i < NUM_GND) ? 5'(i + 1) : 5'(i + 1);

    hold_timer u_timer (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .cross_i   (comp_sync_q[i] != comp_prev_q[i]),
      .enable_i  (timer_en_q[i]),
      .length_i  (hold_len_q),
      .high_o    (timer_high[i])
    );

    assign ana_sel[i] = (analog_q[CHAN_MSB:CHAN_LSB] == CH);

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
      if (sys_rst_i)
      begin
        pull_en_o[i]     <= 1'b0;
        high_level_o[i]  <= 1'b0;
        pull_up_o[i]     <= 1'b0;
        comp_status_o[i] <= 1'b0;
      end
      else
      begin
        if (ana_sel[i])
        begin
          pull_en_o[i]    <= (ana_cur == ACUR_LOW) || (ana_cur == ACUR_HIGH);
          high_level_o[i] <= (ana_cur == ACUR_HIGH);
          pull_up_o[i]    <= 1'b1;
        end
        else
        begin
          pull_en_o[i]    <= !hiz_q[i];
          high_level_o[i] <= level_q[i] && timer_high[i];
          pull_up_o[i]    <= 1'b1;
        end
        comp_status_o[i] <= comp_sync_q[i] && !ana_sel[i];
      end
    end
  end

  // ----------------------------------------
  // analog mux and status outputs
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      analog_en_o   <= 1'b0;
      analog_chan_o <= CHAN_NONE;
    end
    else
    begin
      analog_en_o   <= (analog_q[CHAN_MSB:CHAN_LSB] >= CHAN_GND0)
                       && (analog_q[CHAN_MSB:CHAN_LSB] <= CHAN_LAST);
      analog_chan_o <= analog_q[CHAN_MSB:CHAN_LSB];
    end
  end

  assign calibrated_o  = calibrated_q;
  assign hold_cycles_o = hold_len_q;

endmodule : switch_input_config_decoder

/* File: swcfg_pkg.sv */
// package: constants and types for the switch input config decoder
// assumes a 125 MHz system clock and a 24-bit serial command frame
package swcfg_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int unsigned FRAME_BITS   = 24;
  localparam int unsigned NUM_PROG     = 8;
  localparam int unsigned NUM_GND      = 14;
  localparam int unsigned NUM_INPUTS   = 22;
  localparam int unsigned CODE_MSB     = 23;
  localparam int unsigned CODE_LSB     = 16;

  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_LEVEL_PROG = 8'h04;
  localparam logic [7:0] CMD_LEVEL_GND  = 8'h05;
  localparam logic [7:0] CMD_ANALOG     = 8'h06;
  localparam logic [7:0] CMD_TIMER_PROG = 8'h07;
  localparam logic [7:0] CMD_TIMER_GND  = 8'h08;
  localparam logic [7:0] CMD_HIZ_PROG   = 8'h09;
  localparam logic [7:0] CMD_HIZ_GND    = 8'h0a;
  localparam logic [7:0] CMD_CALIBRATE  = 8'h0b;
  localparam logic [7:0] CMD_RESET      = 8'h7f;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned CUR_SEL_MSB  = 6;
  localparam int unsigned CUR_SEL_LSB  = 5;
  localparam int unsigned CHAN_MSB     = 4;
  localparam int unsigned CHAN_LSB     = 0;
  localparam logic [4:0]  CHAN_NONE    = 5'h00;
  localparam logic [4:0]  CHAN_GND0    = 5'h01;
  localparam logic [4:0]  CHAN_PROG0   = 5'h0f;
  localparam logic [4:0]  CHAN_LAST    = 5'h16;

  // analog current select encodings
  localparam logic [1:0] ACUR_HIZ      = 2'h0;
  localparam logic [1:0] ACUR_LOW      = 2'h1;
  localparam logic [1:0] ACUR_HIGH     = 2'h2;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [21:0] LEVEL_RESET  = 22'h3fffff;
  localparam logic [21:0] TIMER_RESET  = 22'h3fffff;
  localparam logic [21:0] HIZ_RESET    = 22'h3fffff;
  localparam logic [6:0]  ANALOG_RESET = 7'h00;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned HOLD_MS      = 20;
  localparam int unsigned CAL_PULSE_US = 512;
  localparam int unsigned HOLD_CYCLES  = HOLD_MS * 1000 * CLK_MHZ;
  localparam int unsigned CAL_CYCLES   = CAL_PULSE_US * CLK_MHZ;
  localparam int unsigned CNT_W        = 32;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  code;
    logic [15:0] data;
  } frame_type;

  typedef struct packed {
    logic        pull_en;
    logic        high_level;
    logic        pull_up;
  } drive_type;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_ARMED,
    CAL_MEASURE
  } cal_state_type;

endpackage : swcfg_pkg

/* File: hold_timer.sv */
// one input's high-current hold timer
// assumes crossing strobes on the system clock and a shared tick length
`timescale 1ns/1ps
module hold_timer
  import swcfg_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             cross_i,
  input  wire logic             enable_i,
  input  wire logic [CNT_W-1:0] length_i,
  output logic                  high_o
);

  logic [CNT_W-1:0] count_q;
  logic             run_q;

  // ----------------------------------------
  // countdown
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      count_q <= '0;
      run_q   <= 1'b0;
    end
    else if (cross_i)
    begin
      count_q <= length_i;
      run_q   <= 1'b1;
    end
    else if (run_q)
    begin
      if (count_q <= 32'd1)
      begin
        run_q <= 1'b0;
      end
      count_q <= count_q - 32'd1;
    end
  end

  // high current while running, or always when disabled
  assign high_o = run_q || !enable_i;

endmodule : hold_timer

/* File: switch_input_config_decoder_asserts.sv */
// checker: port-level properties of the switch input config decoder
// assumes the design top ports and the swcfg_pkg package
`timescale 1ns/1ps
module swcfg_checker (
  input wire logic                             clk_i,
  input wire logic                             sys_rst_i,
  input wire logic                             normal_mode_i,
  input wire logic                             logic_supply_i,
  input wire logic [swcfg_pkg::NUM_INPUTS-1:0] comp_closed_i,
  input wire logic [swcfg_pkg::NUM_INPUTS-1:0] comp_status_o,
  input wire logic [swcfg_pkg::NUM_INPUTS-1:0] pull_en_o,
  input wire logic [swcfg_pkg::NUM_INPUTS-1:0] pull_up_o,
  input wire logic                             analog_en_o,
  input wire logic [4:0]                       analog_chan_o,
  input wire logic                             calibrated_o,
  input wire logic [swcfg_pkg::CNT_W-1:0]      hold_cycles_o
);
  import swcfg_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence chan_held;
    $stable(analog_chan_o) [*2];
  endsequence
  sequence comp_quiet;
    ($stable(comp_closed_i) && !analog_en_o) [*6];
  endsequence
  sequence frames_blocked;
    (!(normal_mode_i && logic_supply_i)) [*6];
  endsequence

  // ----------------------------------------
  // properties
  // ----------------------------------------
  AST_RST_DRIVE: assert property ($past(sys_rst_i) |-> pull_en_o == '0 && !analog_en_o)
    else $error("drive not idle after reset");
  AST_RST_CAL: assert property ($past(sys_rst_i) |-> !calibrated_o && hold_cycles_o == HOLD_CYCLES)
    else $error("calibration not cleared by reset");
  AST_MODE_GATE: assert property (frames_blocked |-> $stable(analog_chan_o))
    else $error("channel changed while frames blocked");
  AST_CHAN_EN: assert property (analog_en_o == (analog_chan_o != 5'h00 && analog_chan_o <= CHAN_LAST))
    else $error("analog enable does not match channel");
  AST_STAT_ZERO: assert property (chan_held ##0 analog_en_o |-> !comp_status_o[analog_chan_o - 5'h01])
    else $error("analog input status not zero");
  AST_PULL_UP: assert property (chan_held ##0 analog_en_o |-> pull_up_o[analog_chan_o - 5'h01])
    else $error("analog input not pulled up");
  AST_COMP_FOLLOW: assert property (comp_quiet |-> comp_status_o == comp_closed_i)
    else $error("status does not follow comparators");
  AST_CAL_HOLD: assert property ($changed(hold_cycles_o) |-> calibrated_o || hold_cycles_o == HOLD_CYCLES)
    else $error("timer length changed without calibration");
endmodule : swcfg_checker

bind switch_input_config_decoder swcfg_checker chk (.clk_i, .sys_rst_i, .normal_mode_i, .logic_supply_i,
  .comp_closed_i, .comp_status_o, .pull_en_o, .pull_up_o, .analog_en_o, .analog_chan_o, .calibrated_o,
  .hold_cycles_o);

/* File: swcfg_host.sv */
// host model: serial master sending frames and calibration pulses
// assumes sclk idles low and runs at a 64 ns period inside frames
`timescale 1ns/1ps
module swcfg_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o
);
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end

  // ----------------------------------------
  // frame of n bits, msb first
  // ----------------------------------------
  task automatic send(input logic [23:0] f, input int n);
    cs_n_o = 1'b0;
    #35;
    for (int k = 0; k < n; k++)
    begin
      sdi_o = f[23-k];
      #32 sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
    end
    #32 cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #70;
  endtask : send

  // ----------------------------------------
  // calibration low pulse, other lines still
  // ----------------------------------------
  task automatic cal_pulse(input int t);
    cs_n_o = 1'b0;
    #t;
    cs_n_o = 1'b1;
    #70;
  endtask : cal_pulse
endmodule : swcfg_host

/* File: switch_input_config_decoder_test.sv */
// testbench: drives frames through the host model, checks drive outputs
// assumes swcfg_pkg, swcfg_host and the bound checker
`timescale 1ns/1ps
module switch_input_config_decoder_test;
  import swcfg_pkg::*;
  typedef struct { int sel; logic [31:0] exp; } note_type;
  logic                  clk_i = 1'b0;
  logic                  sys_rst_i = 1'b1;
  logic                  normal_mode_i, logic_supply_i, sclk, cs_n, sdi, analog_en_o, calibrated_o;
  logic [NUM_INPUTS-1:0] comp_closed_i, comp_status_o, pull_en_o, high_level_o, pull_up_o;
  logic [4:0]            analog_chan_o, ch;
  logic [4:0]            chans [4] = '{5'h01, 5'h0e, 5'h0f, 5'h16};
  logic [CNT_W-1:0]      hold_cycles_o;
  logic [7:0]            rp;
  logic [13:0]           rg;
  logic [31:0]           e;
  int                    fails = 0, check_count = 0, i;
  note_type              notes[$], n;
  event                  look;

  always #4 clk_i = ~clk_i;

  swcfg_host host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));
  switch_input_config_decoder uut (.clk_i, .sys_rst_i, .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
    .normal_mode_i, .logic_supply_i, .comp_closed_i, .comp_status_o, .pull_en_o, .high_level_o,
    .pull_up_o, .analog_en_o, .analog_chan_o, .calibrated_o, .hold_cycles_o);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic logic [31:0] seen(input int sel);
    case (sel)
      0: return {10'h000, pull_en_o};
      1: return {10'h000, high_level_o};
      2: return {10'h000, comp_status_o};
      3: return {10'h000, pull_up_o};
      4: return {26'h0, analog_en_o, analog_chan_o};
      5: return {31'h0, calibrated_o};
      6: return hold_cycles_o;
      7: return {31'h0, high_level_o[3]};
      default: return {31'h0, hold_cycles_o >= 32'd560 && hold_cycles_o <= 32'd700};
    endcase
  endfunction : seen

  task expect_out(input int sel, input logic [31:0] v);
    notes.push_back('{sel, v});
    -> look;
    @(negedge clk_i);
  endtask : expect_out

  task cmd(input logic [7:0] c, input logic [15:0] d);
    host.send({c, d}, 24);
    repeat (8) @(negedge clk_i);
  endtask : cmd

  task summarize;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  always @(look)
  begin
    n = notes.pop_front();
    check(seen(n.sel), n.exp);
  end

  initial
  begin
    #500000;
    fails++;
    summarize();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    normal_mode_i = 1'b1;
    logic_supply_i = 1'b1;
    comp_closed_i = '0;
    i = $urandom(32'h35bee4ce);
    repeat (8) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    expect_out(0, 32'h0);
    expect_out(5, 32'h0);
    expect_out(6, HOLD_CYCLES);
    $display("test reset done");
    rp = 8'($urandom);
    rg = 14'($urandom);
    cmd(CMD_HIZ_PROG, {8'h00, rp});
    cmd(CMD_HIZ_GND, {2'b00, rg});
    expect_out(0, {10'h000, ~rp, ~rg});
    cmd(8'h0c, 16'h0000);
    host.send({CMD_HIZ_PROG, 16'h00ff}, 23);
    normal_mode_i = 1'b0;
    cmd(CMD_HIZ_GND, 16'h0000);
    normal_mode_i = 1'b1;
    logic_supply_i = 1'b0;
    cmd(CMD_HIZ_GND, 16'h0000);
    logic_supply_i = 1'b1;
    expect_out(0, {10'h000, ~rp, ~rg});
    $display("test refused frames done");
    rp = 8'($urandom);
    rg = 14'($urandom);
    cmd(CMD_TIMER_PROG, 16'h0000);
    cmd(CMD_TIMER_GND, 16'h0000);
    cmd(CMD_HIZ_PROG, 16'h0000);
    cmd(CMD_HIZ_GND, 16'h0000);
    cmd(CMD_LEVEL_PROG, {8'h00, rp});
    cmd(CMD_LEVEL_GND, {2'b00, rg});
    comp_closed_i = 22'h3fffff;
    repeat (8) @(negedge clk_i);
    expect_out(1, {10'h000, rp, rg});
    expect_out(0, 32'h3fffff);
    $display("test level done");
    cmd(CMD_HIZ_PROG, 16'h00ff);
    cmd(CMD_HIZ_GND, 16'h3fff);
    for (i = 0; i < 4; i++)
    begin
      ch = chans[i];
      cmd(CMD_ANALOG, {9'h000, i[1:0], ch});
      expect_out(4, {26'h0, 1'b1, ch});
      e = 32'h3fffff;
      e[ch - 5'h01] = 1'b0;
      expect_out(2, e);
      expect_out(0, (i == 1 || i == 2) ? 32'h1 << (ch - 5'h01) : 32'h0);
      expect_out(3, 32'h3fffff);
    end
    cmd(CMD_ANALOG, 16'h0000);
    expect_out(4, 32'h0);
    $display("test analog done");
    cmd(CMD_CALIBRATE, 16'hffff);
    host.cal_pulse(128);
    repeat (8) @(negedge clk_i);
    expect_out(5, 32'h1);
    expect_out(8, 32'h1);
    cmd(CMD_TIMER_PROG, 16'h00ff);
    cmd(CMD_TIMER_GND, 16'h3fff);
    cmd(CMD_LEVEL_GND, 16'h3fff);
    cmd(CMD_HIZ_GND, 16'h0000);
    comp_closed_i[3] = 1'b0;
    repeat (8) @(negedge clk_i);
    expect_out(7, 32'h1);
    repeat (720) @(negedge clk_i);
    expect_out(7, 32'h0);
    comp_closed_i[3] = 1'b1;
    repeat (8) @(negedge clk_i);
    expect_out(7, 32'h1);
    $display("test timer done");
    cmd(CMD_RESET, 16'h0000);
    expect_out(0, 32'h0);
    expect_out(5, 32'h0);
    expect_out(6, HOLD_CYCLES);
    $display("test reset command done");
    summarize();
  end
endmodule : switch_input_config_decoder_test
